// [hw/dac_serial_map.vh]
// Purpose: Named constants for the serial frame front end of the eight-channel converter.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef DAC_SERIAL_MAP_VH
`define DAC_SERIAL_MAP_VH

// Frame geometry.
`define WORD_BITS        16
`define COUNT_BITS       5
`define COUNT_FULL       5'h10
`define COUNT_ABORT      5'h0F
`define COUNT_MAX        5'h1F
`define COUNT_ZERO       5'h00
`define COUNT_STEP       5'h01

// Fields of the committed word.
`define CMD_MSB          15
`define CMD_LSB          13
`define CHAN_MSB         12
`define CHAN_LSB         10
`define TERM_MSB         9
`define TERM_LSB         8
`define DATA_MSB         7
`define DATA_LSB         0

// Command codes.
`define CMD_WRITE_REG    3'h0
`define CMD_WRITE_UPDATE 3'h1
`define CMD_POWER_DOWN   3'h2
`define CMD_UPDATE_ALL   3'h3
`define CMD_WRITE_ALL    3'h4

// Channel layout and reset values.
`define CHANNELS         8
`define CODE_BITS        8
`define CODE_RESET       8'h00
`define WORD_RESET       16'h0000
`define PD_RESET         8'h00
`define TERM_RESET       2'h0

`endif

// [hw/pin_sync3.v]
// Purpose: Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes: Pin is asynchronous to core_clk.
// Notes:   The level only changes once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync3
#(
  parameter RESET_LEVEL = 1'b0
)
(
  input  wire core_clk,
  input  wire reset_n,
  input  wire pin,
  output reg  level
);

  reg stage1;
  reg stage2;
  reg stage3;

  // Stage one feeds only stage two, so a metastable value never reaches logic.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= RESET_LEVEL;
      stage2 <= RESET_LEVEL;
      stage3 <= RESET_LEVEL;
      level  <= RESET_LEVEL;
    end
    else
    begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3)
        level <= stage3;
    end
  end

endmodule

// [hw/dac_serial_frame_input.v]
// Purpose: Serial write front end of an eight-channel 8-bit converter with daisy-chain output.
// Assumes: core_clk at 125 MHz; serial clock, frame sync and data arrive asynchronously and
//          are oversampled, so the serial clock must stay well below a quarter of core_clk.
// Notes:   Word fields: [15:13] command, [12:10] channel, [9:8] power-down termination,
//          [7:0] code.
// Functional notes
// [RULE1] After frame sync falls, shift data in on each serial clock falling edge.
// [RULE2] Chain output carries shifted-out data only after more than 16 clock cycles.
// [RULE3] Frame sync rising after the sixteenth falling edge commits the word and updates.
// [RULE4] Frame sync rising before the fifteenth falling edge aborts; converter state unchanged.
// [RULE5] Committed word selects mode, power-down condition and channel register or output value.
// [RULE6] After power-up all channel outputs stay zero until a first valid word.
// [RULE7] Frame sync rising between fifteenth and sixteenth falling edge also aborts.
`timescale 1ns/1ps
`include "dac_serial_map.vh"
module dac_serial_frame_input
(
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        serial_clk,
  input  wire        frame_sync_n,
  input  wire        serial_in,
  output reg         chain_out,
  output reg  [15:0] committed_word,
  output reg         word_commit,
  output reg         frame_abort,
  output reg  [63:0] channel_code,
  output reg  [7:0]  channel_power_down,
  output reg  [1:0]  power_down_term,
  output reg         outputs_valid
);

  wire sclk_level;
  wire sync_level;
  wire data_level;

  reg        sclk_prev;
  reg        sync_prev;
  reg [15:0] shift_word;
  reg [4:0]  edge_count;
  reg [7:0]  input_reg [0:7];

  wire sclk_fall;
  wire sync_fall;
  wire sync_rise;
  wire frame_open;

  wire [2:0] word_cmd;
  wire [2:0] word_chan;
  wire [7:0] word_data;
  wire [1:0] word_term;

  integer i;

  pin_sync3 #(.RESET_LEVEL(1'b1)) u_sync_sclk
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (serial_clk),
    .level    (sclk_level)
  );

  pin_sync3 #(.RESET_LEVEL(1'b1)) u_sync_frame
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (frame_sync_n),
    .level    (sync_level)
  );

  pin_sync3 #(.RESET_LEVEL(1'b0)) u_sync_data
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pin      (serial_in),
    .level    (data_level)
  );

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sclk_prev <= 1'b1;
      sync_prev <= 1'b1;
    end
    else
    begin
      sclk_prev <= sclk_level;
      sync_prev <= sync_level;
    end
  end

  assign sclk_fall  = sclk_prev & ~sclk_level;
  assign sync_fall  = sync_prev & ~sync_level;
  assign sync_rise  = ~sync_prev & sync_level;
  assign frame_open = ~sync_level;

  // A clock edge that coincides with the frame sync fall is taken as part of the frame.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_word <= `WORD_RESET;
      edge_count <= `COUNT_ZERO;
      chain_out  <= 1'b0;
    end
    else if (sync_fall)
    begin
      shift_word <= `WORD_RESET;
      chain_out  <= 1'b0;
      if (sclk_fall)
      begin
        shift_word <= {{(`WORD_BITS-1){1'b0}}, data_level}; // [RULE1]
        edge_count <= `COUNT_STEP;
      end
      else
        edge_count <= `COUNT_ZERO;
    end
    else if (frame_open && sclk_fall)
    begin
      shift_word <= {shift_word[`WORD_BITS-2:0], data_level}; // [RULE1]
      if (edge_count != `COUNT_MAX)
        edge_count <= edge_count + `COUNT_STEP;
      // The bit leaving the top only goes out once a whole word is already held.
      if (edge_count >= `COUNT_FULL)
        chain_out <= shift_word[`WORD_BITS-1]; // [RULE2]
      else
        chain_out <= 1'b0;
    end
    else if (!frame_open)
    begin
      edge_count <= `COUNT_ZERO;
      chain_out  <= 1'b0; // [RULE2]
    end
  end

  // Word fields.
  assign word_cmd  = shift_word[`CMD_MSB:`CMD_LSB];
  assign word_chan = shift_word[`CHAN_MSB:`CHAN_LSB];
  assign word_term = shift_word[`TERM_MSB:`TERM_LSB];
  assign word_data = shift_word[`DATA_MSB:`DATA_LSB];

  // Commit or abort on the frame sync rising edge.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      committed_word <= `WORD_RESET;
      word_commit    <= 1'b0;
      frame_abort    <= 1'b0;
    end
    else
    begin
      word_commit <= 1'b0;
      frame_abort <= 1'b0;
      if (sync_rise)
      begin
        if (edge_count >= `COUNT_FULL)
        begin
          committed_word <= shift_word; // [RULE3]
          word_commit    <= 1'b1; // [RULE3]
        end
        else if (edge_count < `COUNT_ABORT)
          frame_abort <= 1'b1; // [RULE4]
        else
          frame_abort <= 1'b1; // [RULE7]
      end
    end
  end

  // Converter state only moves on a committed word, so an aborted frame leaves it untouched.
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < `CHANNELS; i = i + 1)
        input_reg[i] <= `CODE_RESET;
      channel_code       <= {`CHANNELS{`CODE_RESET}}; // [RULE6]
      channel_power_down <= `PD_RESET;
      power_down_term    <= `TERM_RESET;
      outputs_valid      <= 1'b0; // [RULE6]
    end
    else if (sync_rise && edge_count >= `COUNT_FULL)
    begin
      case (word_cmd) // [RULE5]
        `CMD_WRITE_REG:
        begin
          input_reg[word_chan] <= word_data;
        end
        `CMD_WRITE_UPDATE:
        begin
          input_reg[word_chan] <= word_data;
          for (i = 0; i < `CHANNELS; i = i + 1)
          begin
            if (i == word_chan)
              channel_code[i*`CODE_BITS +: `CODE_BITS] <= word_data;
            else
              channel_code[i*`CODE_BITS +: `CODE_BITS] <= input_reg[i];
          end
          outputs_valid <= 1'b1;
        end
        `CMD_POWER_DOWN:
        begin
          channel_power_down <= word_data;
          power_down_term    <= word_term;
        end
        `CMD_UPDATE_ALL:
        begin
          for (i = 0; i < `CHANNELS; i = i + 1)
            channel_code[i*`CODE_BITS +: `CODE_BITS] <= input_reg[i];
          outputs_valid <= 1'b1;
        end
        `CMD_WRITE_ALL:
        begin
          for (i = 0; i < `CHANNELS; i = i + 1)
          begin
            input_reg[i] <= word_data;
            channel_code[i*`CODE_BITS +: `CODE_BITS] <= word_data;
          end
          outputs_valid <= 1'b1;
        end
        default:
        begin
          input_reg[word_chan] <= input_reg[word_chan];
        end
      endcase
    end
  end

endmodule

// [tb/dac_frame_checker_assertions.sv]
// Purpose: Concurrent checks on the ports of the serial frame front end.
// Assumes: One core_clk domain, reset_n asynchronous and active low.
// Notes:   Bound to the design after the module.
`timescale 1ns/1ps
module dac_frame_checker
(
  input wire        core_clk,
  input wire        reset_n,
  input wire        frame_sync_n,
  input wire        chain_out,
  input wire [15:0] committed_word,
  input wire        word_commit,
  input wire        frame_abort,
  input wire [63:0] channel_code,
  input wire        outputs_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Eight idle cycles cover the synchroniser delay after a frame ends.
  sequence sync_idle;
    frame_sync_n [*8];
  endsequence
  chain_idle_a: assert property (sync_idle |-> !chain_out)
    else $error("chain output active between frames");
  commit_on_rise_a: assert property (word_commit |-> frame_sync_n && $past(frame_sync_n, 4))
    else $error("commit without frame end");
  commit_pulse_a: assert property (word_commit |=> !word_commit)
    else $error("commit pulse too long");
  word_hold_a: assert property (!word_commit |-> $stable(committed_word))
    else $error("word changed without commit");
  abort_keep_a: assert property (frame_abort |-> !word_commit && $stable(channel_code))
    else $error("abort changed state");
  abort_on_rise_a: assert property (frame_abort |-> frame_sync_n)
    else $error("abort while frame open");
  zero_until_valid_a: assert property (!outputs_valid |-> channel_code == 64'h0)
    else $error("output nonzero before first write");
  write_all_a: assert property (word_commit && committed_word[15:13] == 3'h4
    |-> channel_code == {8{committed_word[7:0]}} && outputs_valid)
    else $error("write all not applied");
endmodule
bind dac_serial_frame_input dac_frame_checker u_dac_frame_checker(.core_clk, .reset_n, .frame_sync_n,
  .chain_out, .committed_word, .word_commit, .frame_abort, .channel_code, .outputs_valid);

// [tb/host_model.sv]
// Purpose: Host controller model driving frame sync, serial clock and data.
// Assumes: Serial clock period 125 ns, clock idles high between frames.
// Notes:   Data is inverted on release so a stale bit is never read as valid.
`timescale 1ns/1ps
module host_model
(
  output reg serial_clk,
  output reg frame_sync_n,
  output reg serial_in
);
  integer i;
  initial
  begin
    serial_clk = 1'b1;
    frame_sync_n = 1'b1;
    serial_in = 1'b0;
  end
  // Sends the low n bits of w, most significant first, one per falling edge.
  task send(input [31:0] w, input integer n);
  begin
    // Callers start on a core clock falling edge; the quarter nanosecond keeps every
    // pin change of the frame off the core clock's sampling edges.
    #0.25;
    frame_sync_n = 1'b0;
    for (i = n - 1; i >= 0; i = i - 1)
    begin
      serial_in = w[i];
      #62.5 serial_clk = 1'b0;
      #62.5 serial_clk = 1'b1;
    end
    #62.5 serial_in = ~serial_in;
    frame_sync_n = 1'b1;
    #150;
  end
  endtask
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench for the serial frame front end.
// Assumes: Host model paces the link; pulses are counted as they pass.
// Notes:   Each scenario checks its own results.
`timescale 1ns/1ps
module testbench;
  reg         core_clk;
  reg         reset_n;
  reg         chain_seen;
  reg  [7:0]  chain_bits;
  wire        serial_clk, frame_sync_n, serial_in, chain_out, word_commit, frame_abort, outputs_valid;
  wire [15:0] committed_word;
  wire [63:0] channel_code;
  wire [7:0]  channel_power_down;
  wire [1:0]  power_down_term;
  integer     miscompares, check_count, commits, aborts;
  dac_serial_frame_input u_dac_serial_frame_input(.core_clk, .reset_n, .serial_clk, .frame_sync_n,
    .serial_in, .chain_out, .committed_word, .word_commit, .frame_abort, .channel_code,
    .channel_power_down, .power_down_term, .outputs_valid);
  host_model u_host_model(.serial_clk, .frame_sync_n, .serial_in);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    if (word_commit === 1'b1) commits = commits + 1;
    if (frame_abort === 1'b1) aborts = aborts + 1;
    if (chain_out === 1'b1) chain_seen = 1'b1;
  end
  always @(posedge serial_clk)
    chain_bits <= {chain_bits[6:0], chain_out};
  task check(input [63:0] exp, input [63:0] got, input string what);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // One frame, then the number of commit and abort pulses it produced.
  task frame(input [31:0] w, input integer n, input integer c);
    integer c0, a0;
  begin
    @(negedge core_clk);
    c0 = commits;
    a0 = aborts;
    u_host_model.send(w, n);
    check(c, commits - c0, "commit pulses");
    check(1 - c, aborts - a0, "abort pulses");
  end
  endtask
  task t_abort;
  begin
    frame(32'h80A5, 14, 0);
    frame(32'h80A5, 15, 0);
    check(64'h0, channel_code, "channel_code");
    check(0, outputs_valid, "outputs_valid");
    $display("t_abort done");
  end
  endtask
  task t_write;
  begin
    frame(32'h80A5, 16, 1);
    check(16'h80A5, committed_word, "committed_word");
    check({8{8'hA5}}, channel_code, "channel_code");
    check(1, outputs_valid, "outputs_valid");
    frame(32'h083C, 16, 1);
    check({8{8'hA5}}, channel_code, "channel_code");
    frame(32'h6000, 16, 1);
    check(64'hA5A5A5A5A53CA5A5, channel_code, "channel_code");
    frame(32'h4255, 16, 1);
    check(8'h55, channel_power_down, "channel_power_down");
    check(2'h2, power_down_term, "power_down_term");
    frame(32'h2C77, 16, 1);
    check(64'hA5A5A5A5773CA5A5, channel_code, "channel_code");
    frame(32'hE012, 16, 1);
    check(16'hE012, committed_word, "committed_word");
    check(64'hA5A5A5A5773CA5A5, channel_code, "channel_code");
    check(8'h55, channel_power_down, "channel_power_down");
    frame(32'h2011, 15, 0);
    check(16'hE012, committed_word, "committed_word");
    check(64'hA5A5A5A5773CA5A5, channel_code, "channel_code");
    $display("t_write done");
  end
  endtask
  task t_chain;
  begin
    chain_seen = 1'b0;
    frame(32'h80F0, 16, 1);
    check(0, chain_seen, "chain_out quiet");
    chain_bits = 8'h00;
    frame(32'hA5800F, 24, 1);
    check(1, chain_seen, "chain_out active");
    check(8'hA5, chain_bits, "chain_out bits");
    check(16'h800F, committed_word, "committed_word");
    check({8{8'h0F}}, channel_code, "channel_code");
    $display("t_chain done");
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  initial
  begin
    #300000;
    miscompares = miscompares + 1;
    results();
  end
  initial
  begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    chain_seen = 1'b0;
    {miscompares, check_count, commits, aborts} = 0;
    repeat (10) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (5) @(negedge core_clk);
    check(64'h0, channel_code, "channel_code");
    t_abort();
    t_write();
    t_chain();
    results();
  end
endmodule
